// ===== hdl/timer_front_params.svh
// Offsets, field positions, reset values and codes of the timer front end
`ifndef TIMER_FRONT_PARAMS_SVH
`define TIMER_FRONT_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_STATUS_CONTROL 6'h00
`define IDX_MODE 6'h01
`define IDX_COUNT 6'h02
`define IDX_FAULT_INPUT_CONTROL 6'h29

// Status and control fields
`define PS_LSB 0
`define PS_MSB 2
`define CS_LSB 3
`define CS_MSB 4

// Mode fields
`define WPD_BIT 2

// Fault input control fields
`define FLT_EN_LSB 0
`define FLT_EN_MSB 3
`define FILT_EN_LSB 4
`define FILT_EN_MSB 7

// Count register fields
`define CNT_LSB 0
`define CNT_MSB 15
`define PSC_LSB 16
`define PSC_MSB 22

// Reset values
`define SC_RST 8'h00
`define MODE_RST 8'h00
`define FLT_RST 8'h00

// Bus response codes
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ===== hdl/timer_front_pkg.sv
// Shared types of the timer front end
package timer_front_pkg;

  // Counter clock source codes, in field order
  typedef enum logic [1:0] {
    CS_OFF,
    CS_SYS,
    CS_FIXED,
    CS_EXT
  } clk_sel_t;

  // Register decode result
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_SC,
    SEL_MODE,
    SEL_FLT,
    SEL_CNT
  } reg_sel_t;

endpackage

// ===== hdl/edge_sync.sv
// Two-stage synchroniser with rising-edge detector
`timescale 1ns/1ps
module edge_sync (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic d_i,
  output logic rise_o
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // Shift chain; first stage feeds only the second
  always_comb begin
    st_nxt = st_r;
    if (ce_i) begin
      st_nxt.meta = d_i;
      st_nxt.sync = st_r.meta;
      st_nxt.last = st_r.sync;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // One pulse per synchronised rising edge
  assign rise_o = st_r.sync & ~st_r.last;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  // Pulse never lasts two cycles while running
  rise_single_a: assert property (rise_o && ce_i |=> !rise_o) // see RULE15
    else $error("edge pulse longer than one cycle");

endmodule

// ===== hdl/timer_clock_prescale_fault_ctrl.sv
// Timer front end: clock select, prescaler, fault input control, AXI4-Lite registers
// What this block does
// RULE1: Fault control bits 7..4 enable filters of fault inputs 3..0.
// RULE2: Fault control bits 3..0 enable fault inputs 3..0.
// RULE3: Fault control writes take effect only while write protect disable is 1.
// RULE4: Everything runs on the system clock; other clocks are sampled.
// RULE5: Two-bit clock select picks one of three sources, or 0 stops.
// RULE6: Clock select resets to zero, so the counter does not advance.
// RULE7: Clock select is readable and writable at any time.
// RULE8: Clock select zero stops counting, keeps the count, touches nothing else.
// RULE9: Fixed-frequency clock never runs faster than the system clock.
// RULE10: External clock passes a system-clock synchroniser.
// RULE11: External clock stays at or below a quarter of system clock.
// RULE12: Selected clock feeds a seven-bit prescaler counter.
// RULE13: Three-bit prescale field sets the division ratio.
// RULE14: Division is two to the prescale value; counter steps per rollover.
// RULE15: Synchronised clock rising edges become single count enable pulses.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "timer_front_params.svh"
module timer_clock_prescale_fault_ctrl #(
  parameter int ADDR_W = 8
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic ext_clk_i,
  input wire logic fixed_clk_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [3:0] fault_input_en_o,
  output logic [3:0] fault_filter_en_o,
  output logic count_tick_o,
  output logic [15:0] count_o
);

  typedef struct packed {
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [1:0] clock_select;
    logic [2:0] prescale_select;
    logic write_protect_disable;
    logic [7:0] fault_ctl;
    logic [6:0] psc;
    logic [15:0] count;
    logic count_tick;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic ext_rise;
  logic fixed_rise;
  logic wr_do;
  logic tick_sel;
  logic rollover;
  timer_front_pkg::reg_sel_t wr_sel;

  // Word-address decode shared by both channels
  function automatic timer_front_pkg::reg_sel_t decode(input logic [ADDR_W-1:0] a);
    logic [5:0] idx;
    idx = a[7:2];
    case (idx)
      `IDX_STATUS_CONTROL: decode = timer_front_pkg::SEL_SC;
      `IDX_MODE: decode = timer_front_pkg::SEL_MODE;
      `IDX_COUNT: decode = timer_front_pkg::SEL_CNT;
      `IDX_FAULT_INPUT_CONTROL: decode = timer_front_pkg::SEL_FLT;
      default: decode = timer_front_pkg::SEL_NONE;
    endcase
  endfunction

  // Mask of low prescaler bits for a ratio of two to the power ps
  function automatic logic [6:0] psc_mask(input logic [2:0] ps);
    psc_mask = 7'((8'h01 << ps) - 8'h01);
  endfunction

  // Sampled external and fixed clocks, edges only
  edge_sync u_ext_sync (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .d_i(ext_clk_i),
    .rise_o(ext_rise)
  ); // see RULE10

  edge_sync u_fixed_sync (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .d_i(fixed_clk_i),
    .rise_o(fixed_rise)
  ); // see RULE4

  // Source pick and prescaler rollover
  always_comb begin
    case (timer_front_pkg::clk_sel_t'(st_r.clock_select))
      timer_front_pkg::CS_SYS: tick_sel = 1'b1; // see RULE5
      timer_front_pkg::CS_FIXED: tick_sel = fixed_rise; // see RULE15
      timer_front_pkg::CS_EXT: tick_sel = ext_rise; // see RULE15
      default: tick_sel = 1'b0; // see RULE8
    endcase
    rollover = tick_sel && ((st_r.psc & psc_mask(st_r.prescale_select))
      == psc_mask(st_r.prescale_select)); // see RULE14
    wr_do = st_r.aw_have && st_r.w_have && !st_r.bvalid;
    wr_sel = decode(st_r.aw_addr);
  end

  // Next state: bus slave, registers, prescaler, counter
  always_comb begin
    st_nxt = st_r;
    if (ce_i) begin
      // Write address and data taken in either order
      if (s_axi_awvalid && st_r.awready) begin
        st_nxt.aw_have = 1'b1;
        st_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_r.wready) begin
        st_nxt.w_have = 1'b1;
        st_nxt.w_data = s_axi_wdata;
        st_nxt.w_strb = s_axi_wstrb;
      end
      // Register write once both halves are held
      if (wr_do) begin
        st_nxt.aw_have = 1'b0;
        st_nxt.w_have = 1'b0;
        st_nxt.bvalid = 1'b1;
        st_nxt.bresp = `RESP_OKAY;
        case (wr_sel)
          timer_front_pkg::SEL_SC: begin
            if (st_r.w_strb[0]) begin
              st_nxt.clock_select = st_r.w_data[`CS_MSB:`CS_LSB]; // see RULE7
              st_nxt.prescale_select = st_r.w_data[`PS_MSB:`PS_LSB]; // see RULE13
            end
          end
          timer_front_pkg::SEL_MODE: begin
            if (st_r.w_strb[0]) begin
              st_nxt.write_protect_disable = st_r.w_data[`WPD_BIT];
            end
          end
          timer_front_pkg::SEL_FLT: begin
            // Protected: silently ignored unless unlocked
            if (st_r.w_strb[0] && st_r.write_protect_disable) begin // see RULE3
              st_nxt.fault_ctl = st_r.w_data[7:0];
            end
          end
          timer_front_pkg::SEL_CNT: begin
            st_nxt.bresp = `RESP_OKAY;
          end
          default: begin
            st_nxt.bresp = `RESP_SLVERR;
          end
        endcase
      end
      if (st_r.bvalid && s_axi_bready) begin
        st_nxt.bvalid = 1'b0;
      end
      st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid;
      st_nxt.wready = !st_nxt.w_have && !st_nxt.bvalid;
      // Read channel
      if (st_r.rvalid && s_axi_rready) begin
        st_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_r.arready) begin
        st_nxt.rvalid = 1'b1;
        st_nxt.rresp = `RESP_OKAY;
        st_nxt.rdata = 32'h0000_0000;
        case (decode(s_axi_araddr))
          timer_front_pkg::SEL_SC: begin
            st_nxt.rdata[`CS_MSB:`CS_LSB] = st_r.clock_select; // see RULE7
            st_nxt.rdata[`PS_MSB:`PS_LSB] = st_r.prescale_select;
          end
          timer_front_pkg::SEL_MODE: begin
            st_nxt.rdata[`WPD_BIT] = st_r.write_protect_disable;
          end
          timer_front_pkg::SEL_FLT: begin
            st_nxt.rdata[7:0] = st_r.fault_ctl;
          end
          timer_front_pkg::SEL_CNT: begin
            st_nxt.rdata[`CNT_MSB:`CNT_LSB] = st_r.count;
            st_nxt.rdata[`PSC_MSB:`PSC_LSB] = st_r.psc;
          end
          default: begin
            st_nxt.rresp = `RESP_SLVERR;
          end
        endcase
      end
      st_nxt.arready = !st_nxt.rvalid;
      // Seven-bit prescaler; count kept when source is off
      st_nxt.count_tick = 1'b0;
      if (rollover) begin
        st_nxt.psc = 7'h00; // see RULE12
        st_nxt.count = st_r.count + 16'h0001; // see RULE14
        st_nxt.count_tick = 1'b1;
      end else if (tick_sel) begin
        st_nxt.psc = st_r.psc + 7'h01; // see RULE12
      end
    end
  end

  // Single clock domain state register
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin // see RULE4
    if (!rstn_i) begin
      st_r <= '0;
      st_r.clock_select <= 2'(`SC_RST >> `CS_LSB); // see RULE6
      st_r.prescale_select <= 3'(`SC_RST >> `PS_LSB);
      st_r.write_protect_disable <= 1'(`MODE_RST >> `WPD_BIT);
      st_r.fault_ctl <= `FLT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = st_r.rdata;
  assign fault_input_en_o = st_r.fault_ctl[`FLT_EN_MSB:`FLT_EN_LSB]; // see RULE2
  assign fault_filter_en_o = st_r.fault_ctl[`FILT_EN_MSB:`FILT_EN_LSB]; // see RULE1
  assign count_tick_o = st_r.count_tick;
  assign count_o = st_r.count;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  // Unlocked fault control write
  sequence flt_open_wr_s;
    ce_i && wr_do && wr_sel == timer_front_pkg::SEL_FLT && st_r.w_strb[0]
      && st_r.write_protect_disable;
  endsequence

  // Locked fault control write
  sequence flt_locked_wr_s;
    ce_i && wr_do && wr_sel == timer_front_pkg::SEL_FLT && !st_r.write_protect_disable;
  endsequence

  flt_filter_en_a: assert property (flt_open_wr_s |=> // see RULE1
      fault_filter_en_o == $past(st_r.w_data[7:4]))
    else $error("filter enables not loaded from bits 7..4");

  flt_input_en_a: assert property (flt_open_wr_s |=> // see RULE2
      fault_input_en_o == $past(st_r.w_data[3:0]))
    else $error("input enables not loaded from bits 3..0");

  flt_protect_a: assert property (flt_locked_wr_s |=> // see RULE3
      $stable(fault_input_en_o) && $stable(fault_filter_en_o))
    else $error("locked fault control changed");

  cs_reset_a: assert property (@(posedge ref_clk_i) disable iff (1'b0) // see RULE6
      !rstn_i |=> st_r.clock_select == 2'b00 || !rstn_i)
    else $error("clock select not zero after reset");

  cs_anytime_a: assert property (ce_i && wr_do && wr_sel == timer_front_pkg::SEL_SC // see RULE7
      && st_r.w_strb[0] |=> st_r.clock_select == $past(st_r.w_data[4:3]))
    else $error("clock select write lost");

  cs_stop_hold_a: assert property (st_r.clock_select == 2'b00 |=> // see RULE8
      $stable(count_o) && !count_tick_o)
    else $error("counter moved with no clock selected");

  sys_div1_a: assert property (ce_i && st_r.clock_select == 2'b01 // see RULE5
      && st_r.prescale_select == 3'd0 |=> count_o == $past(count_o) + 16'h0001)
    else $error("system clock did not advance counter");

  ext_pulse_a: assert property (ce_i && st_r.clock_select == 2'b11 && ext_rise // see RULE15
      && st_r.prescale_select == 3'd0 |=> count_tick_o)
    else $error("external edge gave no count");

  psc_ratio_a: assert property (count_tick_o && $past(ce_i) && $past(st_r.clock_select) // see RULE14
      == 2'b01 && $past(st_r.prescale_select) == 3'd2 && $stable(st_r.prescale_select)
      |-> !$past(count_tick_o) && !$past(count_tick_o, 2) && !$past(count_tick_o, 3)
      || $past(st_r.clock_select, 3) != 2'b01 || $past(st_r.prescale_select, 3) != 3'd2)
    else $error("prescale ratio four violated");

  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready && ce_i |=> s_axi_rvalid) // see RULE7
    else $error("read not answered next cycle");

  // External pin rise with a steady source behind it
  sequence ext_pin_rise_s;
    $past(ce_i) && ce_i && $rose(ext_clk_i) && st_r.clock_select == 2'b11
      && st_r.prescale_select == 3'd0;
  endsequence

  // Source and enable held through both synchroniser stages and the detector
  sequence ext_steady_s;
    (ce_i && st_r.clock_select == 2'b11 && st_r.prescale_select == 3'd0) [*3];
  endsequence

  // Pin rise counts on the third edge: two sync stages plus the detector
  ext_delay_a: assert property (ext_pin_rise_s ##0 ext_steady_s |=> count_tick_o) // see RULE10
    else $error("external pin rise not counted after synchroniser");

  // Fixed clock edges count like external ones
  fixed_pulse_a: assert property (ce_i && st_r.clock_select == 2'b10 && fixed_rise // see RULE15
      && st_r.prescale_select == 3'd0 |=> count_tick_o)
    else $error("fixed clock edge gave no count");

  // Prescaler frozen with no source
  stop_psc_a: assert property (st_r.clock_select == 2'b00 |=> $stable(st_r.psc)) // see RULE8
    else $error("prescaler moved with no clock selected");

  // Each tick comes with exactly one counter step
  count_step_a: assert property (count_tick_o && $past(ce_i) |-> // see RULE14
      count_o == $past(count_o) + 16'h0001)
    else $error("tick without single counter step");

  // Clock enable low freezes counter, fault control and bus answers
  freeze_a: assert property (!ce_i |=> $stable(count_o) && $stable(fault_input_en_o) // see RULE4
      && $stable(s_axi_bvalid) && $stable(s_axi_rvalid))
    else $error("state changed while clock enable low");

  // Write answer comes the edge after both halves are held
  wr_answer_a: assert property (ce_i && wr_do |=> s_axi_bvalid) // see RULE7
    else $error("write not answered next cycle");

  // No new write accepted while the answer stands
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) // see RULE7
    else $error("write accepted while response pending");

endmodule

// ===== testbench/clock_source_model.sv
// Behavioural source of the external and fixed-frequency clock pins
`timescale 1ns/1ps
module clock_source_model (
  input wire logic ref_clk_i,
  input wire logic ext_run_i,
  input wire logic fixed_run_i,
  input wire logic [3:0] half_i,
  output logic ext_clk_o,
  output logic fixed_clk_o
);
  int cnt;
  initial begin
    ext_clk_o = 1'b0;
    fixed_clk_o = 1'b0;
    cnt = 0;
  end
  // Toggle every half_i cycles, phase offset from the system clock; idle pins stay low
  always @(posedge ref_clk_i) begin
    #7;
    cnt = (cnt + 1 >= int'(half_i)) ? 0 : cnt + 1;
    if (!ext_run_i) begin
      ext_clk_o = 1'b0;
    end else if (cnt == 0) begin
      ext_clk_o = !ext_clk_o;
    end
    if (!fixed_run_i) begin
      fixed_clk_o = 1'b0;
    end else if (cnt == 0) begin
      fixed_clk_o = !fixed_clk_o;
    end
  end
endmodule

// ===== testbench/timer_clock_prescale_fault_ctrl_bench.sv
// Self-checking bench of the timer front end
`timescale 1ns/1ps
`include "timer_front_params.svh"
module timer_clock_prescale_fault_ctrl_bench;
  logic ref_clk, rstn, ce, ext_run, fixed_run, ext_clk, fixed_clk, tick;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, v;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, flt_en, filt_en, half;
  logic [1:0] bresp, rresp;
  logic [15:0] count, snap;
  int errors, num_checks, seed, ext_rises, fixed_rises, n;
  localparam logic [7:0] A_SC = {`IDX_STATUS_CONTROL, 2'b00};
  localparam logic [7:0] A_MODE = {`IDX_MODE, 2'b00};
  localparam logic [7:0] A_FLT = {`IDX_FAULT_INPUT_CONTROL, 2'b00};
  localparam logic [7:0] A_CNT = {`IDX_COUNT, 2'b00};

  timer_clock_prescale_fault_ctrl timer_clock_prescale_fault_ctrl_inst (
    .ref_clk_i(ref_clk), .rstn_i(rstn), .ce_i(ce), .ext_clk_i(ext_clk),
    .fixed_clk_i(fixed_clk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fault_input_en_o(flt_en), .fault_filter_en_o(filt_en), .count_tick_o(tick),
    .count_o(count)
  );
  clock_source_model clock_source_model_inst (
    .ref_clk_i(ref_clk), .ext_run_i(ext_run), .fixed_run_i(fixed_run), .half_i(half),
    .ext_clk_o(ext_clk), .fixed_clk_o(fixed_clk)
  );

  // System clock and pin edge tallies
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ext_clk) ext_rises++;
  always @(posedge fixed_clk) fixed_rises++;

  task automatic print_verdict();
    $display("Checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timeout(input string what);
    errors++;
    $display("ERROR %s expected answer seen timeout", what);
    print_verdict();
  endtask

  // One write; address and data released as each is taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    bit done;
    done = 0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1;
        bready <= 1'b0;
        chk("bresp", 32'(er), 32'(bresp));
      end
    end
    if (!done) timeout("bvalid");
  endtask

  // One read, data and response compared at the answering edge
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit done;
    done = 0;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1;
        rready <= 1'b0;
        chk("rdata", ed, rdata);
        chk("rresp", 32'(er), 32'(rresp));
      end
    end
    if (!done) timeout("rvalid");
  endtask

  task automatic wait_tick(output int cycles);
    cycles = 0;
    do begin
      @(posedge ref_clk);
      cycles++;
    end while (tick !== 1'b1 && cycles < 300);
    if (cycles >= 300) timeout("tick");
  endtask

  // Main sequence
  initial begin
    seed = 64;
    {rstn, ext_run, fixed_run, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    ce = 1'b1;
    half = 4'h2;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk("count", 0, 32'(count));
    axi_rd(A_SC, 0, `RESP_OKAY);
    axi_rd(A_FLT, 0, `RESP_OKAY);
    // Locked fault control ignores writes
    axi_wr(A_FLT, 32'h0000_00ff, 4'hf, `RESP_OKAY);
    chk("fault_input_en", 0, 32'(flt_en));
    chk("fault_filter_en", 0, 32'(filt_en));
    axi_wr(A_MODE, 32'h1 << `WPD_BIT, 4'hf, `RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      axi_wr(A_FLT, 32'(v), 4'hf, `RESP_OKAY);
      chk("fault_input_en", 32'(v[3:0]), 32'(flt_en));
      chk("fault_filter_en", 32'(v[7:4]), 32'(filt_en));
      axi_rd(A_FLT, 32'(v), `RESP_OKAY);
    end
    axi_wr(A_FLT, 32'(~v), 4'h0, `RESP_OKAY);
    axi_wr(A_MODE, 0, 4'hf, `RESP_OKAY);
    axi_wr(A_FLT, 32'(~v), 4'hf, `RESP_OKAY);
    axi_rd(A_FLT, 32'(v), `RESP_OKAY);
    // System source through every prescale ratio
    for (int ps = 0; ps < 8; ps++) begin
      axi_wr(A_SC, (32'h1 << `CS_LSB) | 32'(ps), 4'hf, `RESP_OKAY);
      axi_rd(A_SC, (32'h1 << `CS_LSB) | 32'(ps), `RESP_OKAY);
      wait_tick(n);
      snap = count;
      wait_tick(n);
      chk("tick period", 32'h1 << ps, 32'(n));
      chk("count step", 32'(16'(snap + 16'h1)), 32'(count));
    end
    // Clock enable low freezes the running counter
    axi_wr(A_SC, 32'h1 << `CS_LSB, 4'hf, `RESP_OKAY);
    ce <= 1'b0;
    @(posedge ref_clk);
    snap = count;
    repeat (20) @(posedge ref_clk);
    chk("count frozen", 32'(snap), 32'(count));
    ce <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("count resumed", 32'(16'(snap + 16'h1)), 32'(count));
    // Stopping keeps count and other registers
    axi_wr(A_SC, 32'h5, 4'hf, `RESP_OKAY);
    repeat (3) @(posedge ref_clk);
    snap = count;
    repeat (40) @(posedge ref_clk);
    chk("count held", 32'(snap), 32'(count));
    axi_rd(A_SC, 32'h5, `RESP_OKAY);
    axi_rd(A_FLT, 32'(v), `RESP_OKAY);
    // External and fixed-frequency sources, one count per rising edge
    for (int src = 3; src >= 2; src--) begin
      half = (src == 3) ? 4'(2 + ($random(seed) & 3)) : 4'(1 + ($random(seed) & 1));
      axi_wr(A_SC, 32'(src) << `CS_LSB, 4'hf, `RESP_OKAY);
      repeat (4) @(posedge ref_clk);
      snap = count;
      ext_rises = 0;
      fixed_rises = 0;
      ext_run <= (src == 3);
      fixed_run <= (src == 2);
      repeat (60) @(posedge ref_clk);
      ext_run <= 1'b0;
      fixed_run <= 1'b0;
      repeat (8) @(posedge ref_clk);
      n = (src == 3) ? ext_rises : fixed_rises;
      chk("count edges", 32'(16'(snap + 16'(n))), 32'(count));
    end
    // Count register reads count with an empty prescaler; writes to it ignored
    axi_wr(A_SC, 0, 4'hf, `RESP_OKAY);
    axi_rd(A_CNT, 32'(16'(snap + 16'(n))), `RESP_OKAY);
    axi_wr(A_CNT, 32'h0000_ffff, 4'hf, `RESP_OKAY);
    axi_rd(A_CNT, 32'(16'(snap + 16'(n))), `RESP_OKAY);
    // Reset in mid-run brings back the stopped, locked state
    axi_wr(A_MODE, 32'h1 << `WPD_BIT, 4'hf, `RESP_OKAY);
    axi_wr(A_FLT, 32'h0000_00ff, 4'hf, `RESP_OKAY);
    axi_wr(A_SC, (32'h1 << `CS_LSB) | 32'h3, 4'hf, `RESP_OKAY);
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("fault_input_en after reset", 0, 32'(flt_en));
    chk("fault_filter_en after reset", 0, 32'(filt_en));
    axi_rd(A_SC, 0, `RESP_OKAY);
    axi_rd(A_MODE, 0, `RESP_OKAY);
    repeat (20) @(posedge ref_clk);
    chk("count after reset", 0, 32'(count));
    axi_rd(8'hfc, 0, `RESP_SLVERR);
    axi_wr(8'hfc, 32'h1, 4'hf, `RESP_SLVERR);
    print_verdict();
  end
endmodule
